// ---- hw/smcg_stop_ctrl.sv ----
// Stop-mode clock and power gating controller with AXI4-Lite registers
// Functional notes
// - Entering either stop mode gates off the clocks of all peripheral modules.
// - With debug mode enabled the debug logic keeps its clock in stop while peripherals stay gated.
// - In stop3 the converter runs only if its async clock and the voltage detector are enabled, else standby.
// - In stop3 the clock generator reference runs only with both internal reference enables set, else standby.
// - In both stop modes the real-time counter runs when enabled, else standby.
// - In stop3 the regulator stays in full regulation only when the voltage detector or debug is enabled.
// - In stop3 the crystal oscillator runs only with both external reference enables set, else standby.
// - In high-frequency range the oscillator also needs the voltage detector enabled to run in stop3.
// - A stop2 request with debug mode enabled enters stop3 instead.
// - A stop2 request with low-voltage-in-stop enabled enters stop3 instead.
// - Peripheral clocks halt in stop whatever the debug setting.
// - Stop3 keeps all register state, memory and pins, and resumes from them.
// - Wake from stop2 acts as power-on reset, sets the powerdown flag and holds pins until a 1 is acked.
`timescale 1ns/1ps
`include "smcg_map.svh"

module smcg_stop_ctrl
    import smcg_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // CPU stop and wake
    input  wire logic        stopReq,
    input  wire logic        wakeReq,
    output logic             stopIllegal,
    // Gating outputs
    output smcg_gate_t       gate,
    output smcg_power_t      power,
    output smcg_state_t      stopState,
    // AXI4-Lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // Run or standby for an optional domain
    function automatic smcg_pwr_t keepOn(input logic keep);
        return keep ? SMCG_ON : SMCG_STBY;
    endfunction

    // Known byte offsets
    function automatic logic mapped(input logic [3:0] a);
        return a == `SMCG_OFF_CTRL || a == `SMCG_OFF_STATUS ||
               a == `SMCG_OFF_ACK || a == `SMCG_OFF_DOMAIN;
    endfunction

    smcg_state_t              state;
    smcg_state_t              next_state;
    logic [`SMCG_CTRL_W-1:0]  ctrl;
    logic [`SMCG_CTRL_W-1:0]  next_ctrl;
    logic                     partial_powerdown_flag;
    logic                     pinLatch;
    smcg_power_t              next_power;
    smcg_gate_t               next_gate;

    logic [3:0]               awAddr;
    logic                     awHeld;
    logic [31:0]              wData;
    logic [3:0]               wStrb;
    logic                     wHeld;

    // Control bits
    wire stopEn   = ctrl[`SMCG_B_STOPEN];
    wire ppdc     = ctrl[`SMCG_B_PPDC];
    wire dbgEn    = ctrl[`SMCG_B_DBGEN];
    wire lvdEn    = ctrl[`SMCG_B_LVDEN];
    wire lvStopEn = ctrl[`SMCG_B_LVSTOPEN];
    wire irefEn   = ctrl[`SMCG_B_IREFEN];
    wire irefSt   = ctrl[`SMCG_B_INTERNAL_REF_STOP_ENABLE];
    wire erefEn   = ctrl[`SMCG_B_EREFEN];
    wire erefSt   = ctrl[`SMCG_B_EXTERNAL_REF_STOP_ENABLE];
    wire hiRange  = ctrl[`SMCG_B_HIRANGE];
    wire adcAclk  = ctrl[`SMCG_B_ADCACLK];
    wire rtcEn    = ctrl[`SMCG_B_RTCEN];

    // Detector is live in stop only with both of its bits
    wire lvdStop  = lvdEn & lvStopEn;

    // Stop entry and mode choice
    wire stopTake  = (state == SMCG_RUN) & stopReq & stopEn;
    // A refused stop keeps all clocks on and raises a one-cycle flag
    wire stopBad   = (state == SMCG_RUN) & stopReq & ~stopEn;
    wire promote   = dbgEn | lvStopEn;
    wire pickStop2 = ppdc & ~promote;

    // Bus handshakes and decode
    wire awFire    = s_axi_awvalid & s_axi_awready;
    wire wFire     = s_axi_wvalid & s_axi_wready;
    wire wrDo      = awHeld & wHeld & ~s_axi_bvalid;
    wire wrCtrl    = wrDo & (awAddr == `SMCG_OFF_CTRL);
    wire wrAck     = wrDo & (awAddr == `SMCG_OFF_ACK) &
                     wStrb[0] & wData[`SMCG_B_ACK];
    wire arFire    = s_axi_arvalid & s_axi_arready;

    assign s_axi_awready = ~awHeld;
    assign s_axi_wready  = ~wHeld;
    assign s_axi_arready = ~s_axi_rvalid;

    // Byte-lane merge into the control word
    wire [31:0] ctrlWide = {{(32 - `SMCG_CTRL_W){1'b0}}, ctrl};
    wire [31:0] ctrlMerged = {
        wStrb[3] ? wData[31:24] : ctrlWide[31:24],
        wStrb[2] ? wData[23:16] : ctrlWide[23:16],
        wStrb[1] ? wData[15:8]  : ctrlWide[15:8],
        wStrb[0] ? wData[7:0]   : ctrlWide[7:0]
    };

    // Status fields placed by position, the rest reads as zero
    logic [31:0] statusWord;
    always_comb begin
        statusWord = 32'h00000000;
        statusWord[`SMCG_B_ST_HI:`SMCG_B_ST_LO] = state;
        statusWord[`SMCG_B_PARTIAL_POWERDOWN_FLAG]                = partial_powerdown_flag;
        statusWord[`SMCG_B_PINHOLD]             = pinLatch;
    end

    // Read data select; the CPU field sits above bit 31 and is left out,
    // since software can only read while the CPU is on
    wire [31:0] domainWord = power[31:0];
    wire [31:0] rdSel =
        (s_axi_araddr == `SMCG_OFF_CTRL)   ? ctrlWide   :
        (s_axi_araddr == `SMCG_OFF_STATUS) ? statusWord :
        (s_axi_araddr == `SMCG_OFF_DOMAIN) ? domainWord :
        32'h00000000;

    // State sequence
    // RUN has three neighbours, so entering stop2 flips both state bits
    always_comb begin
        next_state = state;
        case (state)
            SMCG_RUN: begin
                if (stopTake) begin
                    next_state = pickStop2 ? SMCG_STOP2 : SMCG_STOP3;
                end
            end
            SMCG_STOP3: begin
                if (wakeReq) begin
                    next_state = SMCG_RUN;
                end
            end
            SMCG_STOP2: begin
                if (wakeReq) begin
                    next_state = SMCG_WAKE2;
                end
            end
            SMCG_WAKE2: begin
                next_state = SMCG_RUN;
            end
            default: begin
                next_state = SMCG_RUN;
            end
        endcase
    end

    // Control word update
    always_comb begin
        next_ctrl = ctrl;
        if (wrCtrl) begin
            next_ctrl = ctrlMerged[`SMCG_CTRL_W-1:0];
        end
        if (state == SMCG_WAKE2) begin
            next_ctrl = `SMCG_CTRL_RST;
        end
    end

    // Domain power per mode
    always_comb begin
        next_power = '{default: SMCG_ON};
        next_gate  = '{periphClkEn: 1'b1, debugClkEn: 1'b1, pinHold: pinLatch};
        case (state)
            SMCG_STOP3: begin
                next_gate.periphClkEn = 1'b0;
                next_gate.debugClkEn  = dbgEn;
                next_gate.pinHold     = 1'b1;
                next_power.cpu    = SMCG_STBY;
                next_power.ram    = SMCG_STBY;
                next_power.flash  = SMCG_STBY;
                next_power.ports  = SMCG_STBY;
                next_power.acmp   = SMCG_OFF;
                next_power.iic    = SMCG_STBY;
                next_power.canbus = SMCG_STBY;
                next_power.sci    = SMCG_STBY;
                next_power.spi    = SMCG_STBY;
                next_power.tpm    = SMCG_STBY;
                next_power.adc    = keepOn(adcAclk & lvdStop);
                next_power.clkgen = keepOn(irefEn & irefSt);
                next_power.rtc    = keepOn(rtcEn);
                next_power.vreg   = keepOn(lvdStop | dbgEn);
                next_power.crystal_oscillator   = keepOn(erefEn & erefSt &
                                           (~hiRange | lvdStop));
                next_power.debug  = keepOn(dbgEn);
                next_power.low_voltage_detector    = keepOn(lvdStop);
            end
            SMCG_STOP2: begin
                next_gate.periphClkEn = 1'b0;
                next_gate.debugClkEn  = 1'b0;
                // all off but memory and counter
                next_gate.pinHold     = 1'b1;
                next_power            = '{default: SMCG_OFF};
                next_power.ram        = SMCG_STBY;
                next_power.rtc        = keepOn(rtcEn);
            end
            SMCG_WAKE2: begin
                // Restart holds the pins as they were latched
                next_gate.periphClkEn = 1'b0;
                next_gate.pinHold     = 1'b1;
            end
            default: begin
                next_gate.debugClkEn = 1'b1;
            end
        endcase
    end

    // Mode, control and gating registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state       <= SMCG_RUN;
            ctrl        <= `SMCG_CTRL_RST;
            power       <= '{default: SMCG_ON};
            gate        <= '{periphClkEn: 1'b1, debugClkEn: 1'b1, pinHold: 1'b0};
            stopIllegal <= 1'b0;
        end else begin
            state       <= next_state;
            ctrl        <= next_ctrl;
            power       <= next_power;
            gate        <= next_gate;
            stopIllegal <= stopBad;
        end
    end

    assign stopState = state;

    // Powerdown flag and pin latch; the set wins over an ack in the same cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            partial_powerdown_flag     <= 1'b0;
            pinLatch <= 1'b0;
        end else if (state == SMCG_WAKE2) begin
            partial_powerdown_flag     <= 1'b1;
            pinLatch <= 1'b1;
        end else if (wrAck) begin
            partial_powerdown_flag     <= 1'b0;
            pinLatch <= 1'b0;
        end
    end

    // Write channel capture, either order
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            awHeld <= 1'b0;
            awAddr <= 4'h0;
        end else if (awFire) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
        end else if (wrDo) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wHeld <= 1'b0;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
        end else if (wFire) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end else if (wrDo) begin
            wHeld <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SMCG_RESP_OKAY;
        end else if (wrDo) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awAddr) ? `SMCG_RESP_OKAY : `SMCG_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read answer
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `SMCG_RESP_OKAY;
        end else if (arFire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdSel;
            s_axi_rresp  <= mapped(s_axi_araddr) ? `SMCG_RESP_OKAY : `SMCG_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // smcg_stop_ctrl

// ---- hw/smcg_map.svh ----
// Register map, field positions and codes of the stop-mode gating block
`ifndef SMCG_MAP_SVH
`define SMCG_MAP_SVH

// Byte offsets
`define SMCG_OFF_CTRL     4'h0
`define SMCG_OFF_STATUS   4'h4
`define SMCG_OFF_ACK      4'h8
`define SMCG_OFF_DOMAIN   4'hC

// Control word fields
`define SMCG_CTRL_W        12
`define SMCG_B_STOPEN      0
`define SMCG_B_PPDC        1
`define SMCG_B_DBGEN       2
`define SMCG_B_LVDEN       3
`define SMCG_B_LVSTOPEN    4
`define SMCG_B_IREFEN      5
`define SMCG_B_INTERNAL_REF_STOP_ENABLE    6
`define SMCG_B_EREFEN      7
`define SMCG_B_EXTERNAL_REF_STOP_ENABLE    8
`define SMCG_B_HIRANGE     9
`define SMCG_B_ADCACLK     10
`define SMCG_B_RTCEN       11
`define SMCG_CTRL_RST      12'h018

// Status and acknowledge fields
`define SMCG_B_ST_LO       0
`define SMCG_B_ST_HI       1
`define SMCG_B_PARTIAL_POWERDOWN_FLAG        2
`define SMCG_B_PINHOLD     3
`define SMCG_B_ACK         0

// Bus answers
`define SMCG_RESP_OKAY     2'h0
`define SMCG_RESP_SLVERR   2'h2

`endif

// ---- hw/smcg_pkg.sv ----
// Types of the stop-mode gating block
package smcg_pkg;

    typedef enum logic [1:0] {
        SMCG_RUN   = 2'h0,
        SMCG_STOP3 = 2'h1,
        SMCG_STOP2 = 2'h3,
        SMCG_WAKE2 = 2'h2
    } smcg_state_t;

    typedef enum logic [1:0] {
        SMCG_OFF  = 2'h0,
        SMCG_STBY = 2'h1,
        SMCG_ON   = 2'h2
    } smcg_pwr_t;

    typedef struct packed {
        smcg_pwr_t cpu;
        smcg_pwr_t ram;
        smcg_pwr_t flash;
        smcg_pwr_t ports;
        smcg_pwr_t acmp;
        smcg_pwr_t adc;
        smcg_pwr_t iic;
        smcg_pwr_t clkgen;
        smcg_pwr_t canbus;
        smcg_pwr_t rtc;
        smcg_pwr_t sci;
        smcg_pwr_t spi;
        smcg_pwr_t tpm;
        smcg_pwr_t vreg;
        smcg_pwr_t crystal_oscillator;
        smcg_pwr_t debug;
        smcg_pwr_t low_voltage_detector;
    } smcg_power_t;

    typedef struct packed {
        logic periphClkEn;
        logic debugClkEn;
        logic pinHold;
    } smcg_gate_t;

endpackage

// ---- tb/smcg_stop_ctrl_checker.sv ----
// Concurrent checks on the stop-mode gating outputs
`timescale 1ns/1ps

module smcg_stop_ctrl_checker
    import smcg_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset_n,
    // Watched ports
    input wire logic        wakeReq,
    input wire smcg_gate_t  gate,
    input wire smcg_power_t power,
    input wire smcg_state_t stopState
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Outputs lag the state by one edge, so judge them against the state before
    smcg_state_t prevState;
    logic        inS3;
    logic        inS2;
    assign inS3 = prevState == SMCG_STOP3;
    assign inS2 = prevState == SMCG_STOP2;
    always_ff @(posedge core_clk) prevState <= stopState;

    a_stop_clk_off: assert property ((inS3 || inS2) |-> !gate.periphClkEn)
        else $error("peripheral clock on in stop");
    a_debug_clk: assert property (inS3 |-> gate.debugClkEn == (power.debug == SMCG_ON))
        else $error("debug clock wrong in stop3");
    a_adc_needs_lvd: assert property (inS3 && power.adc == SMCG_ON |-> power.low_voltage_detector == SMCG_ON)
        else $error("converter on without detector");
    a_vreg_full: assert property (inS3 |->
        (power.vreg == SMCG_ON) == (power.low_voltage_detector == SMCG_ON || gate.debugClkEn))
        else $error("regulator mode wrong in stop3");
    a_rtc_kept: assert property ((inS3 || inS2) |-> power.rtc inside {SMCG_ON, SMCG_STBY})
        else $error("counter off in stop");
    a_stop2_domains: assert property (inS2 |-> power.cpu == SMCG_OFF && power.ram == SMCG_STBY
        && power.vreg == SMCG_OFF && power.debug == SMCG_OFF && gate == 3'b001) else $error("stop2 domains wrong");
    a_stop3_standby: assert property (inS3 |-> power.cpu == SMCG_STBY && power.flash == SMCG_STBY
        && power.ram == SMCG_STBY && power.tpm == SMCG_STBY && power.acmp == SMCG_OFF && gate.pinHold)
        else $error("stop3 domains wrong");
    a_stop3_exit: assert property (stopState == SMCG_STOP3 && wakeReq |=> stopState == SMCG_RUN)
        else $error("stop3 exit not direct");
    a_wake2_short: assert property (stopState == SMCG_STOP2 && wakeReq |=>
        stopState == SMCG_WAKE2 ##1 stopState == SMCG_RUN ##1 gate.pinHold) else $error("stop2 wake wrong");
    a_run_all_on: assert property (prevState == SMCG_RUN |-> gate.periphClkEn && power.cpu == SMCG_ON
        && power.acmp == SMCG_ON) else $error("run domains not on");

    c_stop3: cover property (stopState == SMCG_STOP3 && wakeReq);
    c_stop2: cover property (stopState == SMCG_STOP2 && wakeReq);
    c_dbg3: cover property (inS3 && gate.debugClkEn);
endmodule // smcg_stop_ctrl_checker

bind smcg_stop_ctrl smcg_stop_ctrl_checker u_chk (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .wakeReq   (wakeReq),
    .gate      (gate),
    .power     (power),
    .stopState (stopState)
);

// ---- tb/smcg_cpu_model.sv ----
// CPU model issuing stop instructions and wake events
`timescale 1ns/1ps

module smcg_cpu_model (
    // Clock
    input  wire logic core_clk,
    // Stop and wake
    output logic      stopReq,
    output logic      wakeReq
);
    initial begin
        stopReq = 1'b0;
        wakeReq = 1'b0;
    end

    // A stop instruction is a single-cycle pulse
    task automatic exec_stop();
        stopReq <= 1'b1;
        @(posedge core_clk);
        stopReq <= 1'b0;
    endtask

    // Wake held for a prompt or a slow number of cycles
    task automatic raise_wake(input int hold);
        // Wake moves just after a clock edge, like every other input
        @(posedge core_clk);
        wakeReq <= 1'b1;
        repeat (hold) @(posedge core_clk);
        wakeReq <= 1'b0;
    endtask
endmodule // smcg_cpu_model

// ---- tb/smcg_stop_ctrl_tb_top.sv ----
// Self-checking bench of the stop-mode gating controller
`timescale 1ns/1ps
`include "smcg_map.svh"

module smcg_stop_ctrl_tb_top
    import smcg_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        stopReq, wakeReq, stopIllegal;
    smcg_gate_t  gate;
    smcg_power_t power, allOn;
    smcg_state_t stopState;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          error_cnt = 0;
    int          compares = 0;
    int          seed = 32'h9BDD485D;

    always #12.5 core_clk = ~core_clk;

    smcg_stop_ctrl DUT (
        .core_clk(core_clk), .reset_n(reset_n), .stopReq(stopReq), .wakeReq(wakeReq),
        .stopIllegal(stopIllegal), .gate(gate), .power(power), .stopState(stopState),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    smcg_cpu_model cpu (.core_clk(core_clk), .stopReq(stopReq), .wakeReq(wakeReq));

    task automatic test_done();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic guard(inout int n);
        n++;
        if (n > 50) begin
            error_cnt++;
            $display("[FAIL] %0t bus timeout", $time);
            test_done();
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            r = s_axi_bresp;
            guard(n);
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
            guard(n);
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    function automatic smcg_pwr_t on(input logic b);
        return b ? SMCG_ON : SMCG_STBY;
    endfunction

    function automatic smcg_power_t exp_pwr(input logic [11:0] c, input logic deep);
        smcg_power_t p;
        logic        lv;
        lv = c[3] & c[4];
        p = '{default: SMCG_STBY};
        p.acmp = SMCG_OFF;
        p.adc = on(c[10] & lv);
        p.clkgen = on(c[5] & c[6]);
        p.vreg = on(lv | c[2]);
        p.crystal_oscillator = on(c[7] & c[8] & (!c[9] | lv));
        p.debug = on(c[2]);
        p.low_voltage_detector = on(lv);
        if (deep) p = '{default: SMCG_OFF, ram: SMCG_STBY};
        p.rtc = on(c[11]);
        return p;
    endfunction

    task automatic stop_cycle(input logic [11:0] c, input int hold);
        logic [1:0]  r;
        logic [31:0] d;
        logic        deep;
        deep = c[1] & !c[2] & !c[4];
        axi_wr(`SMCG_OFF_CTRL, {20'h0, c}, 4'hF, r);
        cpu.exec_stop();
        repeat (2) @(posedge core_clk);
        #1;
        check(stopState, deep ? SMCG_STOP2 : SMCG_STOP3);
        check(power, exp_pwr(c, deep));
        check(gate, {1'b0, c[2], 1'b1});
        cpu.raise_wake(hold);
        repeat (4) @(posedge core_clk);
        #1;
        check(power, allOn);
        check(gate, {2'b11, deep});
        axi_rd(`SMCG_OFF_STATUS, d, r);
        check(d, deep ? 32'hC : 32'h0);
        axi_rd(`SMCG_OFF_CTRL, d, r);
        check(d, deep ? 32'h18 : {20'h0, c});
        if (deep) begin
            // Only lane 0 carries the acknowledge bit
            axi_wr(`SMCG_OFF_ACK, 32'h1, 4'h1, r);
            repeat (2) @(posedge core_clk);
            #1;
            check(gate, 3'b110);
        end
    endtask

    initial begin
        logic [1:0]  r;
        logic [31:0] d;
        logic        seen;
        logic [11:0] corner [9];
        corner = '{12'h003, 12'h007, 12'h013, 12'h381, 12'h399, 12'h419, 12'h461, 12'h803, 12'hFFF};
        allOn = '{default: SMCG_ON};
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        #1;
        check(power, allOn);
        check(gate, 3'b110);
        axi_rd(`SMCG_OFF_CTRL, d, r);
        check(d, 32'h18);
        axi_wr(`SMCG_OFF_STATUS, 32'hF, 4'hF, r);
        axi_rd(`SMCG_OFF_STATUS, d, r);
        check(d, 32'h0);
        axi_rd(`SMCG_OFF_DOMAIN, d, r);
        check(d, allOn[31:0]);
        axi_rd(4'h2, d, r);
        check({r, d}, {`SMCG_RESP_SLVERR, 32'h0});
        axi_wr(4'h6, 32'h1, 4'hF, r);
        check(r, `SMCG_RESP_SLVERR);
        // Stop with the enable bit clear must raise the flag and leave the peripheral clock running
        cpu.exec_stop();
        seen = 1'b0;
        repeat (3) begin
            #1 seen = seen | stopIllegal;
            @(posedge core_clk);
        end
        check({seen, stopState, gate.periphClkEn}, {1'b1, SMCG_RUN, 1'b1});
        foreach (corner[i]) stop_cycle(corner[i], 1);
        repeat (30) stop_cycle(12'($random(seed)) | 12'h001, 1 + int'($random(seed) & 7));
        test_done();
    end
endmodule // smcg_stop_ctrl_tb_top
